// [hdl/wicm_pkg.sv]
// Package with constants and types for the wake input configuration block.
package wicm_pkg;

    // Pull current selection codes.
    localparam logic [1:0] PULL_NONE = 2'h0;
    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP = 2'h2;
    localparam logic [1:0] PULL_AUTO = 2'h3;

    // Filter and sense selection codes.
    localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
    localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
    localparam logic [1:0] FLT_CYCLIC_ONE = 2'h2;
    localparam logic [1:0] FLT_CYCLIC_TWO = 2'h3;

    // Reset values of the configuration.
    localparam logic [1:0] PULL_RESET = 2'h0;
    localparam logic MEAS_RESET = 1'b0;

    // Filter times in microseconds and the oscillator rate.
    localparam int FILTER_SHORT_US = 16;
    localparam int FILTER_LONG_US = 64;
    localparam int CLK_MHZ = 100;
    localparam int FILTER_SHORT_CYC = FILTER_SHORT_US * CLK_MHZ;
    localparam int FILTER_LONG_CYC = FILTER_LONG_US * CLK_MHZ;
    localparam int CNT_W = 13;

    // Device operating modes seen by this block.
    typedef enum logic [2:0]
    {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } wicm_mode_t;

    // Number of wake inputs.
    localparam int NUM_INPUTS = 3;

endpackage

// [hdl/wicm_filter.sv]
// Per-input synchroniser and wake filter.
`timescale 1ns/1ps
module wicm_filter
#(
    parameter int SHORT_CYC = wicm_pkg::FILTER_SHORT_CYC,
    parameter int LONG_CYC = wicm_pkg::FILTER_LONG_CYC
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Pin and settings.
    input wire logic pinIn,
    input wire logic longSel,
    input wire logic gateOff,
    // Results.
    output logic levelOut,
    output logic edgeOut
);

    localparam int CW = wicm_pkg::CNT_W;

    // Refuse filter counts that the counter cannot reach.
    if (SHORT_CYC < 2 || LONG_CYC < SHORT_CYC || LONG_CYC >= (1 << CW))
    begin : gen_bad_counts
        $error("wicm_filter: filter counts out of range");
    end

    logic [2:0] syncQ;
    logic [2:0] syncD;
    logic rawQ;
    logic rawD;
    logic levelQ;
    logic levelD;
    logic [wicm_pkg::CNT_W-1:0] cntQ;
    logic [wicm_pkg::CNT_W-1:0] cntD;
    logic edgeQ;
    logic edgeD;
    logic [wicm_pkg::CNT_W-1:0] limit;

    // Next values: a crossing restarts the count, stable level commits.
    always_comb
    begin
        syncD = {syncQ[1:0], pinIn};
        rawD = rawQ;
        cntD = cntQ;
        levelD = levelQ;
        edgeD = 1'b0;
        limit = longSel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
        if (syncQ[2] == syncQ[1] && syncQ[2] != rawQ)
        begin
            rawD = syncQ[2];
            cntD = '0;
        end
        else if (rawQ != levelQ)
        begin
            if (cntQ >= limit)
            begin
                levelD = rawQ;
                edgeD = ~gateOff;
            end
            else
            begin
                cntD = cntQ + 1'b1;
            end
        end
    end

    // Registers of the filter.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncQ <= 3'h0;
            rawQ <= 1'b0;
            levelQ <= 1'b0;
            cntQ <= '0;
            edgeQ <= 1'b0;
        end
        else
        begin
            syncQ <= syncD;
            rawQ <= rawD;
            levelQ <= levelD;
            cntQ <= cntD;
            edgeQ <= edgeD;
        end
    end

    assign levelOut = levelQ;
    assign edgeOut = edgeQ;

    // A short pulse never reaches the filtered level.
    glitch_reject_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $changed(levelQ) |->
        $past(rawQ) == levelQ && $past(cntQ) >= $past(limit))
        else $error("Level changed without a settled input.");

endmodule // wicm_filter

// [hdl/wicm_top.sv]
// Wake input configuration, filtering and voltage measurement control.
`timescale 1ns/1ps
module wicm_top
#(
    parameter int SHORT_CYC = wicm_pkg::FILTER_SHORT_CYC,
    parameter int LONG_CYC = wicm_pkg::FILTER_LONG_CYC
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst_n,
    // Wake pins.
    input wire logic hvInputOne,
    input wire logic hvInputTwo,
    input wire logic hvInputThree,
    // Configuration held by the register file.
    input wire logic [5:0] pullCurrentControl,
    input wire logic [5:0] senseFilterControl,
    input wire logic [2:0] wakeEnableControl,
    input wire logic measureEnable,
    input wire wicm_pkg::wicm_mode_t opMode,
    input wire logic sleepCommand,
    // Cyclic sense windows from the two timers.
    input wire logic cyclicTimerOneOn,
    input wire logic cyclicTimerTwoOn,
    // Status clearing.
    input wire logic wakeStatusClear,
    // Analog controls.
    output logic [2:0] pullUpEnable,
    output logic [2:0] pullDownEnable,
    output logic measureSwitch,
    // Status and events.
    output logic [2:0] wakeEventStatus,
    output logic [2:0] pinLevelStatus,
    output logic wakeInterrupt,
    output logic wakeUpRequest,
    output logic spiFailSet,
    output logic restartRequest
);

    // Returns the pull enables {up, down} for one input.
    function automatic logic [1:0] pullDecode(input logic [1:0] code,
                                              input logic level);
        case (code)
            wicm_pkg::PULL_NONE: pullDecode = 2'h0;
            wicm_pkg::PULL_DOWN: pullDecode = 2'h1;
            wicm_pkg::PULL_UP: pullDecode = 2'h2;
            default: pullDecode = level ? 2'h2 : 2'h1;
        endcase
    endfunction

    logic [2:0] pins;
    logic [2:0] level;
    logic [2:0] edges;
    logic [2:0] gated;
    logic [2:0] active;
    logic measActive;
    logic [2:0] statusQ;
    logic [2:0] statusD;
    logic [2:0] lvlQ;
    logic [2:0] lvlD;
    logic [2:0] puQ;
    logic [2:0] puD;
    logic [2:0] pdQ;
    logic [2:0] pdD;
    logic switchQ;
    logic switchD;
    logic intQ;
    logic intD;
    logic wakeQ;
    logic wakeD;
    logic failQ;
    logic failD;
    logic [1:0] pd;
    logic [1:0] fsel;
    logic normalMode;

    assign pins = {hvInputThree, hvInputTwo, hvInputOne};
    assign normalMode = (opMode == wicm_pkg::MODE_NORMAL);
    // Measurement setting is stored regardless of mode; it gates inputs one and two in every mode.
    assign measActive = measureEnable;
    assign gated = {1'b0, measActive, measActive};

    // One filter per input; short or long time from the filter code.
    genvar gi;
    generate
        for (gi = 0; gi < wicm_pkg::NUM_INPUTS; gi++)
        begin : gen_filt
            wicm_filter
            #(
                .SHORT_CYC(SHORT_CYC),
                .LONG_CYC(LONG_CYC)
            )
            u_filt
            (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .pinIn(pins[gi]),
                .longSel(senseFilterControl[2*gi +: 2] ==
                         wicm_pkg::FLT_STATIC_LONG),
                .gateOff(gated[gi]),
                .levelOut(level[gi]),
                .edgeOut(edges[gi])
            );
        end
    endgenerate

    // Sensing window: static always, cyclic only while the timer is on.
    always_comb
    begin
        for (int i = 0; i < wicm_pkg::NUM_INPUTS; i++)
        begin
            fsel = senseFilterControl[2*i +: 2];
            case (fsel)
                wicm_pkg::FLT_CYCLIC_ONE: active[i] = cyclicTimerOneOn;
                wicm_pkg::FLT_CYCLIC_TWO: active[i] = cyclicTimerTwoOn;
                default: active[i] = 1'b1;
            endcase
        end
    end

    // Next values of pulls, status, level, switch and events.
    always_comb
    begin
        statusD = wakeStatusClear ? 3'h0 : statusQ;
        lvlD = lvlQ;
        puD = 3'h0;
        pdD = 3'h0;
        pd = 2'h0;
        intD = 1'b0;
        wakeD = 1'b0;
        failD = 1'b0;
        for (int i = 0; i < wicm_pkg::NUM_INPUTS; i++)
        begin
            pd = pullDecode(pullCurrentControl[2*i +: 2], level[i]);
            if (!gated[i])
            begin
                puD[i] = pd[1];
                pdD[i] = pd[0];
                if (active[i] && wakeEnableControl[i] && edges[i])
                begin
                    statusD[i] = 1'b1;
                end
                if (active[i])
                begin
                    lvlD[i] = level[i];
                end
            end
        end
        // Set wins over clear on the same cycle.
        for (int i = 0; i < wicm_pkg::NUM_INPUTS; i++)
        begin
            if (!gated[i] && active[i] && wakeEnableControl[i] && edges[i])
            begin
                if (opMode == wicm_pkg::MODE_NORMAL ||
                    opMode == wicm_pkg::MODE_STOP)
                begin
                    intD = 1'b1;
                end
                else if (opMode == wicm_pkg::MODE_SLEEP ||
                         opMode == wicm_pkg::MODE_FAILSAFE)
                begin
                    wakeD = 1'b1;
                end
            end
        end
        switchD = measureEnable && normalMode;
        if (sleepCommand && measureEnable && !wakeEnableControl[2] &&
            (wakeEnableControl[1:0] != 2'h0))
        begin
            failD = 1'b1;
        end
    end

    // Registers of the block.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            statusQ <= 3'h0;
            lvlQ <= 3'h0;
            puQ <= {3{wicm_pkg::PULL_RESET[1]}};
            pdQ <= {3{wicm_pkg::PULL_RESET[0]}};
            switchQ <= wicm_pkg::MEAS_RESET;
            intQ <= 1'b0;
            wakeQ <= 1'b0;
            failQ <= 1'b0;
        end
        else
        begin
            statusQ <= statusD;
            lvlQ <= lvlD;
            puQ <= puD;
            pdQ <= pdD;
            switchQ <= switchD;
            intQ <= intD;
            wakeQ <= wakeD;
            failQ <= failD;
        end
    end

    assign pullUpEnable = puQ;
    assign pullDownEnable = pdQ;
    assign measureSwitch = switchQ;
    assign wakeEventStatus = statusQ;
    assign pinLevelStatus = lvlQ;
    assign wakeInterrupt = intQ;
    assign wakeUpRequest = wakeQ;
    assign spiFailSet = failQ;
    assign restartRequest = failQ;

    // Switch follows enable and Normal mode one cycle later.
    switch_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        measureSwitch == $past(measureEnable && normalMode))
        else $error("Measurement switch does not follow mode.");

    // Switch open from the second cycle outside Normal mode.
    switch_normal_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !normalMode ##1 !normalMode |-> !measureSwitch)
        else $error("Switch closed outside Normal mode.");

    // Pulls of inputs one and two off while measuring.
    meas_pull_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(measureEnable) |->
        (pullUpEnable[1:0] == 2'h0 && pullDownEnable[1:0] == 2'h0))
        else $error("Pull active on gated input.");

    // Status of inputs one and two frozen while measuring.
    meas_status_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(measureEnable) && !$past(wakeStatusClear) |->
        wakeEventStatus[1:0] == $past(wakeEventStatus[1:0]))
        else $error("Status updated from gated input.");

    // Pull code decoding one cycle later.
    pull_code_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(pullCurrentControl[5:4]) == wicm_pkg::PULL_UP |->
        pullUpEnable[2] && !pullDownEnable[2])
        else $error("Pull-up code not decoded.");

    // Automatic pull follows the filtered level.
    auto_pull_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(pullCurrentControl[5:4]) == wicm_pkg::PULL_AUTO |->
        pullUpEnable[2] == $past(level[2]) &&
        pullDownEnable[2] == !$past(level[2]))
        else $error("Automatic pull wrong.");

    // Sleep fault raises flag and restart together.
    sleep_fail_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sleepCommand && measureEnable && !wakeEnableControl[2] &&
        wakeEnableControl[1:0] != 2'h0 |=>
        spiFailSet && restartRequest)
        else $error("Sleep fault not flagged.");

    // Interrupt only in Normal or Stop mode.
    int_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wakeInterrupt |-> $past(opMode) == wicm_pkg::MODE_NORMAL ||
        $past(opMode) == wicm_pkg::MODE_STOP)
        else $error("Interrupt in wrong mode.");

    // Level status of inputs one and two frozen while measuring.
    meas_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(measureEnable) |->
        pinLevelStatus[1:0] == $past(pinLevelStatus[1:0]))
        else $error("Level status updated from gated input.");

    // No-pull code leaves input one without any current source.
    pull_none_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(pullCurrentControl[1:0]) == wicm_pkg::PULL_NONE |->
        !pullUpEnable[0] && !pullDownEnable[0])
        else $error("Current source on with no-pull code.");

    // Pull-down code on input one when not measuring.
    pull_down_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(pullCurrentControl[1:0]) == wicm_pkg::PULL_DOWN &&
        !$past(measureEnable) |->
        pullDownEnable[0] && !pullUpEnable[0])
        else $error("Pull-down code not decoded.");

    // Wake request only in Sleep or Fail-Safe mode.
    wake_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
        wakeUpRequest |-> $past(opMode) == wicm_pkg::MODE_SLEEP ||
        $past(opMode) == wicm_pkg::MODE_FAILSAFE)
        else $error("Wake request in wrong mode.");

    // Scenarios of interest.
    cov_wake_c: cover property (@(posedge sys_clk) wakeUpRequest);
    cov_cyclic_c: cover property (@(posedge sys_clk)
        wakeInterrupt && senseFilterControl[5]);
    cov_int_c: cover property (@(posedge sys_clk) wakeInterrupt);
    cov_switch_c: cover property (@(posedge sys_clk) measureSwitch);
    cov_fail_c: cover property (@(posedge sys_clk) spiFailSet);

endmodule // wicm_top

// [dv/wicm_pin_model.sv]
// Model of the switches and sensors that drive the three wake pins.
`timescale 1ns/1ps
module wicm_pin_model
(
    // Clock.
    input wire logic sys_clk,
    // Drive requests from the bench.
    input wire logic [2:0] driveEn,
    input wire logic [2:0] driveVal,
    // Pull currents from the block.
    input wire logic [2:0] pullUpEnable,
    input wire logic [2:0] pullDownEnable,
    // Pin levels seen by the block.
    output logic [2:0] pinLevel
);
    logic [2:0] floatQ = 3'h0;

    // An open pin with no pull wanders, so it toggles every cycle.
    always @(posedge sys_clk)
    begin
        floatQ <= ~pinLevel;
    end

    // A driven pin wins, then the pull sources, else the wandering level.
    always_comb
    begin
        pinLevel = (driveEn & driveVal) | (~driveEn & pullUpEnable)
            | (~driveEn & ~pullUpEnable & ~pullDownEnable & floatQ);
    end
endmodule // wicm_pin_model

// [dv/tb.sv]
// Self-checking bench for the wake input configuration block.
`timescale 1ns/1ps
module tb;
    localparam int SH = 8;
    localparam int LG = 32;
    localparam int W = SH + 12;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] drvEn = 3'h7;
    logic [2:0] drvVal = 3'h0;
    logic [2:0] pins;
    logic [5:0] pullCtl = 6'h00;
    logic [5:0] fltCtl = 6'h00;
    logic [2:0] wakeEn = 3'h7;
    logic measEn = 1'b0;
    wicm_pkg::wicm_mode_t mode = wicm_pkg::MODE_NORMAL;
    logic sleepCmd = 1'b0;
    logic tOne = 1'b0;
    logic tTwo = 1'b0;
    logic clr = 1'b0;
    logic [2:0] pullUp, pullDown, wakeStat, lvlStat;
    logic measSw, wakeInt, wakeReq, spiFail, restartReq;
    int numErrors = 0;
    int nTests = 0;
    int tick = 0;
    int intCnt = 0;
    int wakeCnt = 0;
    int pairCnt = 0;
    int base;
    int iBase;

    // Clock at 100 MHz.
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    wicm_top #(.SHORT_CYC(SH), .LONG_CYC(LG)) dut_u (.sys_clk(sys_clk),
        .rst_n(rst_n), .hvInputOne(pins[0]), .hvInputTwo(pins[1]),
        .hvInputThree(pins[2]), .pullCurrentControl(pullCtl),
        .senseFilterControl(fltCtl), .wakeEnableControl(wakeEn),
        .measureEnable(measEn), .opMode(mode), .sleepCommand(sleepCmd),
        .cyclicTimerOneOn(tOne), .cyclicTimerTwoOn(tTwo),
        .wakeStatusClear(clr), .pullUpEnable(pullUp),
        .pullDownEnable(pullDown), .measureSwitch(measSw),
        .wakeEventStatus(wakeStat), .pinLevelStatus(lvlStat),
        .wakeInterrupt(wakeInt), .wakeUpRequest(wakeReq),
        .spiFailSet(spiFail), .restartRequest(restartReq));

    wicm_pin_model pin_u (.sys_clk(sys_clk), .driveEn(drvEn),
        .driveVal(drvVal), .pullUpEnable(pullUp),
        .pullDownEnable(pullDown), .pinLevel(pins));

    // Pulse counters and the hang guard.
    always @(posedge sys_clk)
    begin
        intCnt <= intCnt + int'(wakeInt);
        wakeCnt <= wakeCnt + int'(wakeReq);
        pairCnt <= pairCnt + int'(spiFail && restartReq);
        tick <= tick + 1;
        if (tick == 3000)
        begin
            numErrors++;
            endOfTest();
        end
    end

    task automatic chk(input logic [3:0] got, input logic [3:0] exp,
        input string what);
        nTests++;
        if (got !== exp)
        begin
            numErrors++;
            $display("unexpected at %0t: %s got %b want %b", $time, what,
                got, exp);
        end
    endtask

    // Waits n rising edges, then moves to the falling edge to sample.
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask

    // Pulses the status clear for one cycle.
    task automatic clear_status;
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
    endtask

    task automatic endOfTest;
        $display("Comparisons %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        settle(0);
        chk(pullUp | pullDown, 3'h0, "pulls after reset");
        chk({measSw, wakeInt, spiFail}, 3'h0, "switch after reset");
        settle(W);
        chk(wakeStat, 3'h0, "quiet status");
        // Fixed pull codes on all three inputs.
        for (int c = 0; c < 3; c++)
        begin
            @(posedge sys_clk);
            pullCtl <= {3{c[1:0]}};
            settle(2);
            chk(pullUp, (c == 2) ? 3'h7 : 3'h0, "pull up code");
            chk(pullDown, (c == 1) ? 3'h7 : 3'h0, "pull down code");
        end
        // Automatic pulls follow the filtered level; the edge is a wake.
        @(posedge sys_clk);
        pullCtl <= 6'h3F;
        settle(W);
        chk(pullDown, 3'h7, "auto low");
        base = intCnt;
        @(posedge sys_clk);
        drvVal <= 3'h7;
        settle(W);
        chk(pullUp, 3'h7, "auto high up");
        chk(pullDown, 3'h0, "auto high down");
        chk(wakeStat, 3'h7, "static short wake");
        chk(lvlStat, 3'h7, "level status");
        chk(intCnt > base, 3'h1, "interrupt in normal");
        @(posedge sys_clk);
        drvEn <= 3'h0;
        settle(W);
        chk(lvlStat, 3'h7, "held by own pull up");
        @(posedge sys_clk);
        drvEn <= 3'h7;
        pullCtl <= 6'h00;
        fltCtl <= 6'h10;
        clear_status();
        settle(1);
        chk(wakeStat, 3'h0, "status cleared");
        // Pulses shorter than the long filter restart it and never wake.
        repeat (4)
        begin
            @(posedge sys_clk);
            drvVal <= 3'h3;
            repeat (SH + 4) @(posedge sys_clk);
            drvVal <= 3'h7;
            repeat (3) @(posedge sys_clk);
        end
        settle(LG + 12);
        chk(wakeStat, 3'h0, "glitches filtered");
        @(posedge sys_clk);
        drvVal <= 3'h3;
        settle(W);
        chk(wakeStat, 3'h0, "long filter not yet");
        settle(LG);
        chk(wakeStat, 3'h4, "long filter wake");
        // Cyclic sense on timer one, then timer two.
        for (int t = 0; t < 2; t++)
        begin
            clear_status();
            fltCtl <= (t == 0) ? 6'h20 : 6'h30;
            drvVal <= 3'h7;
            tOne <= (t == 1);
            settle(W);
            chk(wakeStat, 3'h0, "window closed");
            chk(lvlStat[2], 1'b0, "level held");
            // The open window also powers the sensor, which then drops.
            @(posedge sys_clk);
            tOne <= (t == 0);
            tTwo <= (t == 1);
            drvVal <= 3'h3;
            settle(W);
            chk(wakeStat, 3'h4, "cyclic wake");
            @(posedge sys_clk);
            tOne <= 1'b0;
            tTwo <= 1'b0;
        end
        // Measurement closes the switch in Normal and gates pins one, two.
        clear_status();
        fltCtl <= 6'h00;
        pullCtl <= 6'h0A;
        measEn <= 1'b1;
        settle(2);
        chk({measSw, pullUp}, 4'h8, "measure normal");
        @(posedge sys_clk);
        drvVal <= 3'h4;
        settle(W);
        chk(wakeStat, 3'h4, "gated status");
        chk(lvlStat, 3'h7, "gated level held");
        @(posedge sys_clk);
        mode <= wicm_pkg::MODE_STOP;
        settle(2);
        chk(measSw, 3'h0, "switch open in stop");
        @(posedge sys_clk);
        wakeEn <= 3'h3;
        sleepCmd <= 1'b1;
        @(posedge sys_clk);
        sleepCmd <= 1'b0;
        settle(3);
        chk(pairCnt == 1, 3'h1, "sleep refused");
        @(posedge sys_clk);
        measEn <= 1'b0;
        wakeEn <= 3'h7;
        mode <= wicm_pkg::MODE_SLEEP;
        settle(W);
        chk(pullUp, 3'h3, "settings kept");
        @(posedge sys_clk);
        wakeEn <= 3'h3;
        sleepCmd <= 1'b1;
        @(posedge sys_clk);
        sleepCmd <= 1'b0;
        wakeEn <= 3'h7;
        settle(3);
        chk(pairCnt == 1, 3'h1, "sleep fine unmeasured");
        // A wake in Sleep raises a wake request, not an interrupt.
        base = wakeCnt;
        iBase = intCnt;
        @(posedge sys_clk);
        drvVal <= 3'h0;
        settle(W);
        chk(wakeCnt > base, 3'h1, "wake from sleep");
        chk(intCnt == iBase, 3'h1, "no interrupt in sleep");
        endOfTest();
    end
endmodule // tb
